// ===== rtl/cdc_map.vh
// Purpose: constants for the clock divider control block
// Assumes: included by bare name from rtl files
// Notes:   definitions only
`ifndef CDC_MAP_VH
`define CDC_MAP_VH

// register byte offsets on the avalon slave
`define CDC_OFS_CTRL        4'h0
`define CDC_OFS_STAT        4'h4
// control register: 16 bits, low half of the data word
`define CDC_CTRL_W          16
`define CDC_CTRL_RST        16'h0222
// field positions (lsb) of the 3-bit selects
`define CDC_BUS_LSB         0
`define CDC_PERIPH_LSB      4
`define CDC_CORE_LSB        8
// status register: pending flag position
`define CDC_STAT_PEND_BIT   12
// select codes (ratio to input clock)
`define CDC_SEL_X8          3'h0
`define CDC_SEL_X4          3'h1
`define CDC_SEL_X2          3'h2
`define CDC_SEL_X1          3'h3
// fixed multiplication of the input clock
`define CDC_MULT            8
// reference phase counter width and last phase
`define CDC_PH_W            3
`define CDC_PH_LAST         3'h7

`endif

// ===== rtl/cdc_div_en.v
// Purpose: one divided clock, given as a one-cycle enable pulse
// Assumes: all dividers share one free phase counter
// Notes:   pulse is registered, so it trails the phase by one cycle
`timescale 1ns/10ps
`default_nettype none
`include "cdc_map.vh"

module cdc_div_en
(
    input  wire                 i_clk,   // multiplied reference clock
    input  wire                 i_rst,   // async, active high
    input  wire [`CDC_PH_W-1:0] i_phase, // shared phase counter
    input  wire [2:0]           i_code,  // effective select, 0..3
    output reg                  o_en     // one pulse per divided period
);

    reg [`CDC_PH_W-1:0] mask;            // low phase bits that must be set

    // ratio code to phase mask: x8 -> /1, x4 -> /2, x2 -> /4, x1 -> /8
    always @*
    begin
        case (i_code)
            `CDC_SEL_X8: mask = 3'h0;
            `CDC_SEL_X4: mask = 3'h1;
            `CDC_SEL_X2: mask = 3'h3;
            default:     mask = 3'h7;
        endcase
    end

    // pulse at the last phase of each period; all periods end at phase 7
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_en <= 1'b0;
        else
            o_en <= ((i_phase & mask) == mask);
    end

endmodule // cdc_div_en

`default_nettype wire

// ===== rtl/cdc_clock_divider.v
// Purpose: clock divider control; derives core, peripheral and bus
//          clock enables from the multiplied reference clock
// Assumes: i_clk is the reference after the fixed multiply by eight
// Notes:   avalon-mm slave with one wait state on every access
//
// Function
// - bit 3 reserved, reads zero
// - bus select bits 2..0, reset x2
// - bus clock never faster than core
// - reference is input clock times eight
// - divide by 1,2,4,8; new selects apply
// - peripheral clock never faster than core
// - changes wait for current bus cycle
// - switch within one bus clock cycle; the code switches at the next phase 7, up to 8 cycles after bus idle
// - peripherals run on peripheral clock enable
// - core select bits 10..8, reset x2
// - peripheral select bits 6..4, reset x2
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "cdc_map.vh"

module cdc_clock_divider
(
    input  wire        i_clk,              // multiplied reference clock
    input  wire        i_rst,              // async reset, active high
    input  wire [3:0]  i_avs_address,      // byte address
    input  wire        i_avs_read,         // read request
    input  wire        i_avs_write,        // write request
    input  wire [31:0] i_avs_writedata,    // write data
    input  wire [3:0]  i_avs_byteenable,   // byte lanes
    output reg  [31:0] o_avs_readdata,     // read data
    output wire        o_avs_waitrequest,  // stall until answer
    input  wire        i_bus_busy,         // external bus cycle running
    output wire        o_core_clk_en,      // core, dma, transfer ctrl
    output wire        o_periph_clk_en,    // on-chip peripherals
    output wire        o_bus_clk_en,       // external bus clock
    output wire        o_cfg_pending       // new selects waiting
);

    // phase counter width is the log2 of the fixed multiply

    reg  [2:0] core_sel_r;      // programmed core select
    reg  [2:0] periph_sel_r;    // programmed peripheral select
    reg  [2:0] bus_sel_r;       // programmed bus select
    reg  [2:0] core_act_r;      // applied core code
    reg  [2:0] periph_act_r;    // applied peripheral code
    reg  [2:0] bus_act_r;       // applied bus code
    reg        pend_r;          // write seen, not yet applied
    reg        ack_r;           // one wait state done
    reg  [`CDC_PH_W-1:0] phase_r;   // shared reference phase
    reg  [2:0] core_nxt;        // clamped core code
    reg  [2:0] periph_nxt;      // clamped peripheral code
    reg  [2:0] bus_nxt;         // clamped bus code
    wire       req;             // any access
    wire       wr_hit;          // accepted write to control
    wire       apply;           // move programmed into applied
    wire [15:0] ctrl_view;      // control register as read

    // forbidden codes 1xx are treated as the slowest ratio
    function [2:0] cdc_legal;
        input [2:0] code;
        begin
            cdc_legal = code[2] ? `CDC_SEL_X1 : code;
        end
    endfunction

    // larger code means slower clock; keep the slower of the two
    function [2:0] cdc_slower;
        input [2:0] a;
        input [2:0] b;
        begin
            cdc_slower = (a > b) ? a : b;
        end
    endfunction

    // avalon handshake: every access waits exactly one cycle
    assign req               = i_avs_read | i_avs_write;
    assign o_avs_waitrequest = req & ~ack_r;
    assign wr_hit            = i_avs_write & ack_r &
                               (i_avs_address == `CDC_OFS_CTRL);

    // ack toggles so back to back requests each get a wait state
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ack_r <= 1'b0;
        else
            ack_r <= req & ~ack_r;
    end

    // reserved bits 3, 7 and above 10 read zero
    assign ctrl_view = {5'h00, core_sel_r, 1'b0, periph_sel_r,
                        1'b0, bus_sel_r};

    // read data registered, valid at the edge waitrequest drops
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read & ~ack_r)
        begin
            case (i_avs_address)
                `CDC_OFS_CTRL:
                    o_avs_readdata <= {16'h0000, ctrl_view};
                `CDC_OFS_STAT:
                    o_avs_readdata <= {19'h0_0000, pend_r,
                                       1'b0, core_act_r,
                                       1'b0, periph_act_r,
                                       1'b0, bus_act_r};
                // unmapped: read as zero
                default:
                    o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // core, peripheral and bus select fields, reset x2; reserved bits dropped
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            core_sel_r   <= `CDC_SEL_X2;
            periph_sel_r <= `CDC_SEL_X2;
            bus_sel_r    <= `CDC_SEL_X2;
        end
        else if (wr_hit)
        begin
            if (i_avs_byteenable[1])
                core_sel_r <= i_avs_writedata[`CDC_CORE_LSB +: 3];
            if (i_avs_byteenable[0])
            begin
                periph_sel_r <= i_avs_writedata[`CDC_PERIPH_LSB +: 3];
                bus_sel_r    <= i_avs_writedata[`CDC_BUS_LSB +: 3];
            end
        end
    end

    // one phase step per reference cycle, eight per input cycle
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            phase_r <= 3'h0;
        else
            phase_r <= phase_r + 3'h1;
    end

    // hold change while the external bus cycle runs
    // apply only where every divided period ends together
    assign apply = pend_r & ~i_bus_busy & (phase_r == `CDC_PH_LAST);

    // pending: a write in the apply cycle keeps it set
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            pend_r <= 1'b0;
        else if (wr_hit)
            pend_r <= 1'b1;
        else if (apply)
            pend_r <= 1'b0;
    end

    assign o_cfg_pending = pend_r;

    // effective codes from the programmed selects
    always @*
    begin
        core_nxt = cdc_legal(core_sel_r);
        // core setting wins over a faster peripheral setting
        periph_nxt = cdc_slower(cdc_legal(periph_sel_r), core_nxt);
        // bus clock clamped to the core frequency
        bus_nxt = cdc_slower(cdc_legal(bus_sel_r), core_nxt);
    end

    // the slowest period is eight cycles, so at most one
    // period of the slowest clock passes between bus idle and the switch
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            core_act_r   <= `CDC_SEL_X2;
            periph_act_r <= `CDC_SEL_X2;
            bus_act_r    <= `CDC_SEL_X2;
        end
        else if (apply)
        begin
            core_act_r   <= core_nxt;
            periph_act_r <= periph_nxt;
            bus_act_r    <= bus_nxt;
        end
    end

    cdc_div_en u_core
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_phase (phase_r),
        .i_code  (core_act_r),
        .o_en    (o_core_clk_en)
    );

    // peripheral divider, feeds all but dma engines
    cdc_div_en u_periph
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_phase (phase_r),
        .i_code  (periph_act_r),
        .o_en    (o_periph_clk_en)
    );

    cdc_div_en u_bus
    (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_phase (phase_r),
        .i_code  (bus_act_r),
        .o_en    (o_bus_clk_en)
    );

endmodule // cdc_clock_divider

`default_nettype wire

// ===== tb/cdc_bus_model.sv
// Purpose: bus master model holding one long bus cycle
// Assumes: shares the reference clock
// Notes:   busy for 12 cycles after a go pulse
`timescale 1ns/10ps
`default_nettype none
module cdc_bus_model
(
    input  wire logic i_clk,  // reference clock
    input  wire logic i_rst,  // async, active high
    input  wire logic i_go,   // start a bus cycle
    output var  logic o_busy  // cycle in progress
);
    logic [3:0] cnt_r; // cycles left
    // countdown; the divider has to wait it out
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_r <= 4'hc;
        else if (i_go)
            cnt_r <= 4'hc;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
    assign o_busy = cnt_r != 4'h0;
endmodule // cdc_bus_model
`default_nettype wire

// ===== tb/cdc_clock_divider_assertions.sv
// Purpose: port checker for the clock divider control
// Assumes: one clock domain
// Notes:   enables all share phase seven
`timescale 1ns/10ps
`default_nettype none
module cdc_clock_divider_assertions
(
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [3:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        i_bus_busy,
    input wire logic        o_core_clk_en,
    input wire logic        o_periph_clk_en,
    input wire logic        o_bus_clk_en,
    input wire logic        o_cfg_pending
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_wr_done;
        i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0
            && i_avs_byteenable[1:0] != 2'b00;
    endsequence
    sequence s_settled;
        !o_cfg_pending || i_bus_busy || i_avs_write;
    endsequence
    property p_wr_pend; s_wr_done |=> o_cfg_pending; endproperty
    a_wr_pend: assert property (p_wr_pend) else $error("no pending");
    property p_hold; o_cfg_pending && i_bus_busy |=> o_cfg_pending;
    endproperty
    a_hold: assert property (p_hold) else $error("early apply");
    property p_apply; o_cfg_pending && !i_bus_busy |-> ##[0:8] s_settled;
    endproperty
    a_apply: assert property (p_apply) else $error("late apply");
    property p_per; o_periph_clk_en |-> o_core_clk_en; endproperty
    a_per: assert property (p_per) else $error("periph fast");
    property p_bus; o_bus_clk_en |-> o_core_clk_en; endproperty
    a_bus: assert property (p_bus) else $error("bus fast");
    property p_gap; !o_bus_clk_en [*8] |=> o_bus_clk_en; endproperty
    a_gap: assert property (p_gap) else $error("bus gap");
    property p_pgap; !o_periph_clk_en [*8] |=> o_periph_clk_en; endproperty
    a_pgap: assert property (p_pgap) else $error("periph gap");
    property p_rsv; i_avs_read && !o_avs_waitrequest && i_avs_address == 4'h0
        |-> (o_avs_readdata & 32'hffff_f888) == 32'h0000_0000; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
endmodule // cdc_clock_divider_assertions
bind cdc_clock_divider cdc_clock_divider_assertions u_chk
(.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
 .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
 .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
 .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
 .i_bus_busy(i_bus_busy), .o_core_clk_en(o_core_clk_en),
 .o_periph_clk_en(o_periph_clk_en), .o_bus_clk_en(o_bus_clk_en),
 .o_cfg_pending(o_cfg_pending));
`default_nettype wire

// ===== tb/cdc_clock_divider_tb.sv
// Purpose: self-checking bench for the clock divider control
// Assumes: 100 MHz reference, one avalon request at a time
// Notes:   clock ratios measured as pulse spacing in cycles
`timescale 1ns/10ps
`default_nettype none
module cdc_clock_divider_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0] be = 4'hf;
    logic go = 1'b0;
    logic [31:0] rdat, q;
    logic wreq, busy;
    wire logic [3:0] sig; // pending, core, periph, bus
    integer n_mismatch = 0, total_checks = 0, i, k, n;
    // rows write legal codes only
    // ctrl word, then core, periph, bus period in cycles
    logic [31:0] rows [5] = '{32'h0000_1110, 32'h0103_2280,
        32'h0210_4440, 32'h0332_8880, 32'h0023_1480};
    cdc_clock_divider DUT
    (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
     .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
     .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_bus_busy(busy),
     .o_core_clk_en(sig[2]), .o_periph_clk_en(sig[1]),
     .o_bus_clk_en(sig[0]), .o_cfg_pending(sig[3]));
    cdc_bus_model u_bus
    (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .o_busy(busy));
    always #5 i_clk = ~i_clk;
    task give_verdict;
    begin
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            n_mismatch = n_mismatch + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    // count cycles until a watched line shows v; cut off at 40
    task seek(input integer s, input logic v, output integer c);
    begin
        c = 0;
        do
        begin
            @(negedge i_clk);
            c = c + 1;
        end while (sig[s] !== v && c < 40);
        // a line that never shows v ends the run as a mismatch
        if (sig[s] !== v)
        begin
            chk(c, 0);
            give_verdict;
        end
    end
    endtask
    // one avalon access, held until waitrequest is seen low at an edge
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] b);
    begin
        k = 0;
        @(posedge i_clk);
        adr <= a;
        wd <= d;
        be <= b;
        wr <= w;
        rd <= ~w;
        @(posedge i_clk);
        while (wreq !== 1'b0 && k < 40)
        begin
            @(posedge i_clk);
            k = k + 1;
        end
        // read data stand at the edge that ends the wait
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (wreq !== 1'b0)
        begin
            chk(k, 0);
            give_verdict;
        end
    end
    endtask
    task per(input integer s, input logic [3:0] e);
    begin
        seek(s, 1'b1, k);
        seek(s, 1'b1, n);
        chk(n, e);
    end
    endtask
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        for (i = 0; i < 5; i = i + 1)
        begin
            acc(1'b1, 4'h0, {16'h0000, rows[i][31:16]}, 4'hf);
            seek(3, 1'b0, k);
            acc(1'b0, 4'h0, 32'h0000_0000, 4'hf);
            chk(q, rows[i][31:16] & 16'h0777);
            per(2, rows[i][15:12]);
            per(1, rows[i][11:8]);
            per(0, rows[i][7:4]);
        end
        @(posedge i_clk);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        acc(1'b1, 4'h0, 32'h0000_0333, 4'hf);
        // status while the bus cycle runs: pending, old codes
        acc(1'b0, 4'h4, 32'h0000_0000, 4'hf);
        chk(q, 32'h0000_1023);
        repeat (4) @(negedge i_clk);
        chk(sig[3], 1'b1);
        seek(3, 1'b0, k);
        // first core period after the switch is a whole one
        seek(2, 1'b1, k);
        chk(k, 8);
        per(2, 4'h8);
        acc(1'b0, 4'h4, 32'h0000_0000, 4'hf);
        chk(q, 32'h0000_0333);
        // unmapped write must not reach the control register
        acc(1'b1, 4'h8, 32'h0000_0111, 4'hf);
        acc(1'b0, 4'h8, 32'h0000_0000, 4'hf);
        chk(q, 32'h0000_0000);
        acc(1'b1, 4'h0, 32'h0000_0000, 4'h1);
        acc(1'b0, 4'h0, 32'h0000_0000, 4'hf);
        chk(q, 32'h0000_0300);
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        acc(1'b0, 4'h0, 32'h0000_0000, 4'hf);
        chk(q, 32'h0000_0222);
        per(1, 4'h4);
        give_verdict;
    end
endmodule // cdc_clock_divider_tb
`default_nettype wire
